// [design/dofs_delay.sv]
// per-terminal switch-on and switch-off delay stage
`timescale 1ns/1ps
`include "dofs_consts.svh"
module dofs_delay #(
  parameter int MS_CYC = `DOFS_MS_CYCLES  // clock cycles per millisecond
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             bypass,   // pass level with no delay
  input  wire logic             level_in, // requested state
  input  wire dofs_pkg::dofs_dly_t on_ms,
  input  wire dofs_pkg::dofs_dly_t off_ms,
  output logic                  level_out
);
  import dofs_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [31:0] tick_ff;   // cycles within one millisecond
  logic [15:0] ms_ff;     // elapsed milliseconds since change request
  logic        out_ff;    // delayed level

  // wait is counted from the moment input differs from output; a
  // glitch shorter than the delay restarts the count and is dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      tick_ff <= 32'h0;
      ms_ff   <= 16'h0;
      out_ff  <= 1'b0;
    end else if (bypass || level_in == out_ff) begin
      tick_ff <= 32'h0;
      ms_ff   <= 16'h0;
      out_ff  <= level_in;
    end else if (ms_ff >= (level_in ? on_ms : off_ms)) begin
      out_ff  <= level_in;
      tick_ff <= 32'h0;
      ms_ff   <= 16'h0;
    end else if (tick_ff == 32'(MS_CYC - 1)) begin
      tick_ff <= 32'h0;
      ms_ff   <= ms_ff + 16'h1;
    end else begin
      tick_ff <= tick_ff + 32'h1;
    end
  end

  assign level_out = out_ff;
endmodule

// [design/dofs_top.sv]
// digital output function selector for the four output terminals
// ------------------------------------------------------------
// What this block does
// - four terminals, each with own selection code
// - fast terminal is pulse or on/off output
// - one code may drive several terminals
// - code 0 holds terminal inactive
// - codes 1-4 run, forward, reverse, jog
// - code 5 follows drive fault
// - code 9 when output and reference zero
// - codes 10, 11 upper and lower limit
// - code 12 power up, no protection, ready
// - code 13 during pre-excitation
// - codes 14, 15 overload and underload prealarm
// - codes 16, 17 sequencer stage and cycle
// - codes 23-25, 34 follow fieldbus bits
// - code 26 bus above undervoltage
// - code 27 index pulse held 10 ms
// - code 28 superposition, 29 safe torque off
// - codes 30-32 positioning and spindle done
// - code 33 speed limit, 36 switchover done
// - code 37 ramp reference above detection
// - codes 41-47 expansion card bits passed
// - codes 48-50 overheat prealarms
// - codes 51-56 zero speed, tension, diameters, fire
// - four-bit polarity mask inverts outputs
// - separate on and off delays per terminal
// - fast terminal delays only in on/off mode
// ------------------------------------------------------------
`timescale 1ns/1ps
`include "dofs_consts.svh"
module dofs_top #(
  parameter int MS_CYC    = `DOFS_MS_CYCLES,  // cycles per millisecond
  parameter int ZPULSE_CYC = `DOFS_ZPULSE_CYC // index pulse stretch length
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  // configuration from the control core
  input  wire dofs_pkg::dofs_fast_mode_e fast_mode,
  input  wire dofs_pkg::dofs_sel_t  sel_collector,
  input  wire dofs_pkg::dofs_sel_t  sel_fast,
  input  wire dofs_pkg::dofs_sel_t  sel_relay_a,
  input  wire dofs_pkg::dofs_sel_t  sel_relay_b,
  input  wire logic [3:0]           polarity,
  input  wire dofs_pkg::dofs_dly_t  on_dly_collector,
  input  wire dofs_pkg::dofs_dly_t  off_dly_collector,
  input  wire dofs_pkg::dofs_dly_t  on_dly_fast,
  input  wire dofs_pkg::dofs_dly_t  off_dly_fast,
  input  wire dofs_pkg::dofs_dly_t  on_dly_relay_a,
  input  wire dofs_pkg::dofs_dly_t  off_dly_relay_a,
  input  wire dofs_pkg::dofs_dly_t  on_dly_relay_b,
  input  wire dofs_pkg::dofs_dly_t  off_dly_relay_b,
  // drive status conditions, same clock
  input  wire logic                 st_running,
  input  wire logic                 st_forward,
  input  wire logic                 st_reverse,
  input  wire logic                 st_jogging,
  input  wire logic                 st_fault,
  input  wire logic                 st_freq_level_detect_a,
  input  wire logic                 st_freq_level_detect_b,
  input  wire logic                 st_freq_reached,
  input  wire logic                 st_out_freq_zero,
  input  wire logic                 st_ref_freq_zero,
  input  wire logic                 st_upper_limit,
  input  wire logic                 st_lower_limit,
  input  wire logic                 st_main_power_ok,
  input  wire logic                 st_ctrl_power_ok,
  input  wire logic                 st_protection_active,
  input  wire logic                 st_ready,
  input  wire logic                 st_pre_exciting,
  input  wire logic                 st_overload_prealarm,
  input  wire logic                 st_underload_prealarm,
  input  wire logic                 st_sequencer_stage_done,
  input  wire logic                 st_sequencer_cycle_done,
  input  wire logic [3:0]           fieldbus_serial_bits,
  input  wire logic [3:0]           fieldbus_can_bits,
  input  wire logic [3:0]           fieldbus_ether_bits,
  input  wire logic [3:0]           fieldbus_rt_ether_bits,
  input  wire logic                 st_dc_bus_ok,
  input  wire logic                 st_index_pulse,
  input  wire logic                 st_superposition,
  input  wire logic                 st_safe_torque_off,
  input  wire logic                 st_position_done,
  input  wire logic                 st_spindle_zero_done,
  input  wire logic                 st_spindle_div_done,
  input  wire logic                 st_torque_speed_limit,
  input  wire logic                 st_mode_switch_done,
  input  wire logic                 st_ramp_above_detect,
  input  wire logic [6:0]           expansion_card_bits,
  input  wire logic                 st_overheat_card_sensor_a,
  input  wire logic                 st_overheat_card_sensor_b,
  input  wire logic                 st_overheat_analog_io_channel,
  input  wire logic                 st_stopped_or_zero,
  input  wire logic                 st_tension_disconnect,
  input  wire logic                 st_diameter_set_reached,
  input  wire logic                 st_diameter_max,
  input  wire logic                 st_diameter_min,
  input  wire logic                 st_fire_mode,
  // terminal outputs
  output logic                      card_collector_out_a,
  output logic                      fast_pulse_terminal,
  output logic                      fast_pulse_is_onoff,
  output logic                      relay_out_a,
  output logic                      relay_out_b
);
  import dofs_pkg::*;

  // ------------------------------------------------------------
  // selection decode
  // ------------------------------------------------------------
  logic [31:0] zcnt_ff;      // index pulse stretch counter
  logic        zpulse_ff;    // stretched index pulse
  logic        zprev_ff;     // previous index pulse level
  logic [3:0]  raw;          // selected condition per terminal
  logic [3:0]  dly;          // delayed condition per terminal
  logic [3:0]  term_ff;      // final terminal states
  logic        fast_mode_ff; // registered fast terminal mode

  // one function serves all four terminals, so a shared code drives
  // each such terminal from the same condition; fieldbus codes 23-25, 34 take the bit of each terminal's own index
  function automatic logic pick(input dofs_sel_t sel, input int unsigned t);
    logic r;
    r = 1'b0;  // idle and reserved codes stay low
    case (sel)
      6'h01: r = st_running;
      6'h02: r = st_forward;
      6'h03: r = st_reverse;
      6'h04: r = st_jogging;
      6'h05: r = st_fault;
      6'h06: r = st_freq_level_detect_a;
      6'h07: r = st_freq_level_detect_b;
      6'h08: r = st_freq_reached;
      6'h09: r = st_out_freq_zero & st_ref_freq_zero;
      6'h0a: r = st_upper_limit;
      6'h0b: r = st_lower_limit;
      6'h0c: r = st_main_power_ok & st_ctrl_power_ok
                 & ~st_protection_active & st_ready;
      6'h0d: r = st_pre_exciting;
      6'h0e: r = st_overload_prealarm;
      6'h0f: r = st_underload_prealarm;
      6'h10: r = st_sequencer_stage_done;
      6'h11: r = st_sequencer_cycle_done;
      6'h17: r = fieldbus_serial_bits[t];
      6'h18: r = fieldbus_can_bits[t];
      6'h19: r = fieldbus_ether_bits[t];
      6'h22: r = fieldbus_rt_ether_bits[t];
      6'h1a: r = st_dc_bus_ok;
      6'h1b: r = zpulse_ff;
      6'h1c: r = st_superposition;
      6'h1d: r = st_safe_torque_off;
      6'h1e: r = st_position_done;
      6'h1f: r = st_spindle_zero_done;
      6'h20: r = st_spindle_div_done;
      6'h21: r = st_torque_speed_limit;
      6'h24: r = st_mode_switch_done;
      6'h25: r = st_ramp_above_detect;
      6'h29: r = expansion_card_bits[0];
      6'h2a: r = expansion_card_bits[1];
      6'h2b: r = expansion_card_bits[2];
      6'h2c: r = expansion_card_bits[3];
      6'h2d: r = expansion_card_bits[4];
      6'h2e: r = expansion_card_bits[5];
      6'h2f: r = expansion_card_bits[6];
      6'h30: r = st_overheat_card_sensor_a;
      6'h31: r = st_overheat_card_sensor_b;
      6'h32: r = st_overheat_analog_io_channel;
      6'h33: r = st_stopped_or_zero;
      6'h34: r = st_tension_disconnect;
      6'h35: r = st_diameter_set_reached;
      6'h36: r = st_diameter_max;
      6'h37: r = st_diameter_min;
      6'h38: r = st_fire_mode;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // index pulse stretcher
  // ------------------------------------------------------------
  // rising edge of the index pulse starts a fixed 10 ms window
  always_ff @(posedge clock) begin
    if (rst) begin
      zprev_ff  <= 1'b0;
      zpulse_ff <= 1'b0;
      zcnt_ff   <= 32'h0;
    end else begin
      zprev_ff <= st_index_pulse;
      if (st_index_pulse && !zprev_ff) begin
        zpulse_ff <= 1'b1;
        zcnt_ff   <= 32'(ZPULSE_CYC - 1);
      end else if (zcnt_ff != 32'h0) begin
        zcnt_ff <= zcnt_ff - 32'h1;
      end else begin
        zpulse_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // per-terminal selection
  // ------------------------------------------------------------
  always_comb begin
    raw[`DOFS_T_COLLECTOR] = pick(sel_collector, `DOFS_T_COLLECTOR);
    raw[`DOFS_T_FAST]      = pick(sel_fast, `DOFS_T_FAST);
    raw[`DOFS_T_RELAY_A]   = pick(sel_relay_a, `DOFS_T_RELAY_A);
    raw[`DOFS_T_RELAY_B]   = pick(sel_relay_b, `DOFS_T_RELAY_B);
  end

  // ------------------------------------------------------------
  // switch delays
  // ------------------------------------------------------------
  dofs_delay #(.MS_CYC(MS_CYC)) u_dly_col (
    .clock(clock), .rst(rst), .bypass(1'b0),
    .level_in(raw[`DOFS_T_COLLECTOR]),
    .on_ms(on_dly_collector), .off_ms(off_dly_collector),
    .level_out(dly[`DOFS_T_COLLECTOR]));

  // fast terminal delays are skipped in pulse mode
  dofs_delay #(.MS_CYC(MS_CYC)) u_dly_fast (
    .clock(clock), .rst(rst), .bypass(fast_mode != dofs_fast_onoff),
    .level_in(raw[`DOFS_T_FAST]),
    .on_ms(on_dly_fast), .off_ms(off_dly_fast),
    .level_out(dly[`DOFS_T_FAST]));

  dofs_delay #(.MS_CYC(MS_CYC)) u_dly_ra (
    .clock(clock), .rst(rst), .bypass(1'b0),
    .level_in(raw[`DOFS_T_RELAY_A]),
    .on_ms(on_dly_relay_a), .off_ms(off_dly_relay_a),
    .level_out(dly[`DOFS_T_RELAY_A]));

  dofs_delay #(.MS_CYC(MS_CYC)) u_dly_rb (
    .clock(clock), .rst(rst), .bypass(1'b0),
    .level_in(raw[`DOFS_T_RELAY_B]),
    .on_ms(on_dly_relay_b), .off_ms(off_dly_relay_b),
    .level_out(dly[`DOFS_T_RELAY_B]));

  // ------------------------------------------------------------
  // polarity and output registers
  // ------------------------------------------------------------
  // inversion after the delay; reset state is all terminals off
  always_ff @(posedge clock) begin
    if (rst) begin
      term_ff      <= 4'h0;
      fast_mode_ff <= 1'b0;
    end else begin
      term_ff      <= dly ^ polarity;
      fast_mode_ff <= (fast_mode == dofs_fast_onoff);
    end
  end

  assign card_collector_out_a = term_ff[`DOFS_T_COLLECTOR];
  assign fast_pulse_terminal  = term_ff[`DOFS_T_FAST];
  assign relay_out_a          = term_ff[`DOFS_T_RELAY_A];
  assign relay_out_b          = term_ff[`DOFS_T_RELAY_B];
  assign fast_pulse_is_onoff  = fast_mode_ff;
endmodule

// [include/dofs_consts.svh]
// timing and encoding constants for the digital output function selector
`ifndef DOFS_CONSTS_SVH
`define DOFS_CONSTS_SVH
`define DOFS_CLK_HZ        40000000
`define DOFS_MS_CYCLES     (`DOFS_CLK_HZ / 1000)
`define DOFS_ZPULSE_MS     10
`define DOFS_ZPULSE_CYC    (`DOFS_ZPULSE_MS * `DOFS_MS_CYCLES)
`define DOFS_DELAY_MAX_MS  50000
`define DOFS_TERMS         4
`define DOFS_SEL_W         6
`define DOFS_DLY_W         16
`define DOFS_T_COLLECTOR   0
`define DOFS_T_FAST        1
`define DOFS_T_RELAY_A     2
`define DOFS_T_RELAY_B     3
`define DOFS_POL_RST       4'h0
`endif

// [include/dofs_pkg.sv]
// types shared by the digital output function selector
package dofs_pkg;
  typedef logic [5:0]  dofs_sel_t;    // function selection code
  typedef logic [15:0] dofs_dly_t;    // delay in milliseconds
  typedef enum logic {
    dofs_fast_pulse,
    dofs_fast_onoff
  } dofs_fast_mode_e;
endpackage

// [sim/digital_output_function_selector_tb.sv]
// testbench for the output function selector
`timescale 1ns/1ps
module digital_output_function_selector_tb;
  import dofs_pkg::*;
  logic                clock;
  logic                rst;
  dofs_fast_mode_e     fast_mode;
  dofs_sel_t           sel [4];      // collector, fast, relay a, relay b
  logic [3:0]          polarity;
  dofs_dly_t           dly [8];      // on/off pairs in the same order
  logic [63:0]         cond;         // bit n is the condition of code n
  logic                prot;         // protection active
  wire logic           col_o, fast_o, onoff_o, ra_o, rb_o;
  wire logic [7:0]     closes;
  logic [7:0]          closes0;      // closings seen before the delay test
  int                  n_errors, total_checks, cycles;
  dofs_top #(.MS_CYC(4), .ZPULSE_CYC(20)) DUT (
    .clock(clock), .rst(rst), .fast_mode(fast_mode), .sel_collector(sel[0]),
    .sel_fast(sel[1]), .sel_relay_a(sel[2]), .sel_relay_b(sel[3]), .polarity(polarity),
    .on_dly_collector(dly[0]), .off_dly_collector(dly[1]), .on_dly_fast(dly[2]),
    .off_dly_fast(dly[3]), .on_dly_relay_a(dly[4]), .off_dly_relay_a(dly[5]),
    .on_dly_relay_b(dly[6]), .off_dly_relay_b(dly[7]),
    .st_running(cond[1]), .st_forward(cond[2]), .st_reverse(cond[3]), .st_jogging(cond[4]),
    .st_fault(cond[5]), .st_freq_level_detect_a(cond[6]), .st_freq_level_detect_b(cond[7]),
    .st_freq_reached(cond[8]), .st_out_freq_zero(cond[9]), .st_ref_freq_zero(!prot),
    .st_upper_limit(cond[10]), .st_lower_limit(cond[11]), .st_main_power_ok(cond[12]),
    .st_ctrl_power_ok(cond[12]), .st_protection_active(prot), .st_ready(cond[12]),
    .st_pre_exciting(cond[13]), .st_overload_prealarm(cond[14]),
    .st_underload_prealarm(cond[15]), .st_sequencer_stage_done(cond[16]),
    .st_sequencer_cycle_done(cond[17]), .fieldbus_serial_bits({4{cond[23]}}),
    .fieldbus_can_bits({4{cond[24]}}), .fieldbus_ether_bits({4{cond[25]}}),
    .fieldbus_rt_ether_bits({4{cond[34]}}), .st_dc_bus_ok(cond[26]),
    .st_index_pulse(cond[27]), .st_superposition(cond[28]), .st_safe_torque_off(cond[29]),
    .st_position_done(cond[30]), .st_spindle_zero_done(cond[31]),
    .st_spindle_div_done(cond[32]), .st_torque_speed_limit(cond[33]),
    .st_mode_switch_done(cond[36]), .st_ramp_above_detect(cond[37]),
    .expansion_card_bits(cond[47:41]), .st_overheat_card_sensor_a(cond[48]),
    .st_overheat_card_sensor_b(cond[49]), .st_overheat_analog_io_channel(cond[50]),
    .st_stopped_or_zero(cond[51]), .st_tension_disconnect(cond[52]),
    .st_diameter_set_reached(cond[53]), .st_diameter_max(cond[54]),
    .st_diameter_min(cond[55]), .st_fire_mode(cond[56]), .card_collector_out_a(col_o),
    .fast_pulse_terminal(fast_o), .fast_pulse_is_onoff(onoff_o), .relay_out_a(ra_o),
    .relay_out_b(rb_o));
  dofs_load u_load (.clock(clock), .rst(rst), .contact(rb_o), .closes(closes));
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic wait_cyc(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic check(string name, logic seen, logic exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, seen);
    end
  endtask
  // collector is inverted by polarity bit 0 throughout the sweep
  task automatic look4(logic e);
    check("collector", col_o, !e);
    check("fast", fast_o, e);
    check("relay_a", ra_o, e);
    check("relay_b", rb_o, e);
  endtask
  function automatic logic active(int c);
    return c inside {[1:17], [23:34], 36, 37, [41:56]};
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    rst = 1'b1; fast_mode = dofs_fast_pulse; polarity = 4'h1; cond = '0; prot = 1'b0;
    foreach (sel[i]) sel[i] = 6'h0;
    foreach (dly[i]) dly[i] = 16'h0;
    wait_cyc(6);
    rst <= 1'b0;
    // every code on all four terminals at once
    for (int c = 0; c < 64; c++) begin
      cond <= '0;
      wait_cyc(25);
      look4(1'b0);
      foreach (sel[i]) sel[i] <= c[5:0];
      wait_cyc(1);
      cond[c] <= 1'b1;
      wait_cyc(4);
      look4(active(c));
    end
    // ready and output and reference zero both drop while protection is active
    sel[2] <= 6'h0c; sel[3] <= 6'h09; cond <= 64'h1200; prot <= 1'b1;
    wait_cyc(4);
    check("ready_prot", ra_o, 1'b0);
    check("zero_ref", rb_o, 1'b0);
    prot <= 1'b0;
    wait_cyc(4);
    check("ready_ok", ra_o, 1'b1);
    check("zero_ref_ok", rb_o, 1'b1);
    // on 3 ms and off 2 ms delays, fast terminal as on/off output
    cond <= '0; fast_mode <= dofs_fast_onoff; sel[1] <= 6'h05; sel[3] <= 6'h05;
    dly[2] <= 16'h3; dly[3] <= 16'h2; dly[6] <= 16'h3; dly[7] <= 16'h2;
    wait_cyc(25);
    check("onoff_flag", onoff_o, 1'b1);
    closes0 = closes;
    cond[5] <= 1'b1;
    wait_cyc(8);
    check("rb_on_early", rb_o, 1'b0);
    check("fast_on_early", fast_o, 1'b0);
    wait_cyc(10);
    check("rb_on", rb_o, 1'b1);
    check("fast_on", fast_o, 1'b1);
    cond[5] <= 1'b0;
    wait_cyc(5);
    check("rb_off_early", rb_o, 1'b1);
    wait_cyc(9);
    check("rb_off", rb_o, 1'b0);
    cond[5] <= 1'b1;
    wait_cyc(4);
    cond[5] <= 1'b0;
    wait_cyc(20);
    check("rb_glitch", rb_o, 1'b0);
    check("closings", closes == 8'(closes0 + 8'h1), 1'b1);
    // pulse mode bypasses the fast terminal delays
    fast_mode <= dofs_fast_pulse;
    cond[5] <= 1'b1;
    wait_cyc(4);
    check("fast_bypass", fast_o, 1'b1);
    check("pulse_flag", onoff_o, 1'b0);
    finish_test();
  end
endmodule

// [sim/dofs_load.sv]
// external load on relay b: counts contact closings
`timescale 1ns/1ps
module dofs_load (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       contact,    // relay contact state
  output logic      [7:0] closes      // closings seen
);
  logic prev_ff;                      // contact one cycle ago
  // count each off to on transition of the contact
  always_ff @(posedge clock) begin
    prev_ff <= rst ? 1'b0 : contact;
    closes  <= rst ? 8'h0 : closes + 8'(contact && !prev_ff);
  end
endmodule

// [sim/dofs_top_props.sv]
// assertions on the ports of the output function selector
`timescale 1ns/1ps
module dofs_top_props #(
  parameter int MS_CYC     = 4,
  parameter int ZPULSE_CYC = 20
) (
  input wire logic                      clock,
  input wire logic                      rst,
  input wire dofs_pkg::dofs_fast_mode_e fast_mode,
  input wire dofs_pkg::dofs_sel_t       sel_collector,
  input wire dofs_pkg::dofs_sel_t       sel_fast,
  input wire dofs_pkg::dofs_sel_t       sel_relay_a,
  input wire dofs_pkg::dofs_sel_t       sel_relay_b,
  input wire logic [3:0]                polarity,
  input wire dofs_pkg::dofs_dly_t       on_dly_collector,
  input wire dofs_pkg::dofs_dly_t       off_dly_collector,
  input wire dofs_pkg::dofs_dly_t       on_dly_relay_a,
  input wire dofs_pkg::dofs_dly_t       off_dly_relay_a,
  input wire dofs_pkg::dofs_dly_t       on_dly_relay_b,
  input wire dofs_pkg::dofs_dly_t       off_dly_relay_b,
  input wire logic                      st_fault,
  input wire logic                      card_collector_out_a,
  input wire logic                      fast_pulse_terminal,
  input wire logic                      fast_pulse_is_onoff,
  input wire logic                      relay_out_a,
  input wire logic                      relay_out_b
);
  import dofs_pkg::*;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic        zd_c;          // collector has no delays
  logic        zd_a;          // relay a has no delays
  logic        zd_b;          // relay b has no delays
  logic [15:0] flt_run_ff;    // consecutive cycles of fault high
  logic [15:0] hi_len_ff;     // consecutive cycles of relay a on
  assign zd_c = on_dly_collector == 16'h0 && off_dly_collector == 16'h0;
  assign zd_a = on_dly_relay_a == 16'h0 && off_dly_relay_a == 16'h0;
  assign zd_b = on_dly_relay_b == 16'h0 && off_dly_relay_b == 16'h0;
  // run length counters, cleared on reset
  always_ff @(posedge clock) begin
    flt_run_ff <= (rst || !st_fault) ? 16'h0 : flt_run_ff + 16'h1;
  end
  always_ff @(posedge clock) begin
    hi_len_ff <= (rst || !relay_out_a) ? 16'h0 : hi_len_ff + 16'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_fault_follow: assert property ((sel_relay_a == 6'h05 && !polarity[2] && zd_a)[*3]
    ##0 !$past(rst, 4) |-> relay_out_a == $past(st_fault, 2))
    else $error("relay a does not follow fault");
  a_polarity_invert: assert property ((sel_collector == 6'h05 && polarity[0] && zd_c)[*3]
    ##0 !$past(rst, 4) |-> card_collector_out_a == !$past(st_fault, 2))
    else $error("collector polarity not inverted");
  a_reserved_idle: assert property ((sel_fast inside {6'h23, [6'h26:6'h28], [6'h39:6'h3f]}
    && !polarity[1] && fast_mode == dofs_fast_pulse)[*3] |-> !fast_pulse_terminal)
    else $error("reserved code drives fast terminal");
  a_code_zero: assert property ((sel_relay_b == 6'h00 && !polarity[3] && zd_b)[*3]
    |-> !relay_out_b)
    else $error("code zero drives relay b");
  a_same_code: assert property ((sel_relay_a == sel_relay_b && polarity[3] == polarity[2]
    && zd_a && zd_b)[*3] |-> relay_out_a == relay_out_b)
    else $error("same code gives different relays");
  a_on_delay_hold: assert property ($rose(relay_out_b) && sel_relay_b == 6'h05 && !polarity[3]
    |-> 32'(flt_run_ff) >= on_dly_relay_b * MS_CYC)
    else $error("relay b switched on early");
  a_index_stretch: assert property ($fell(relay_out_a) && sel_relay_a == 6'h1b
    && $past(sel_relay_a) == 6'h1b && zd_a && !polarity[2]
    |-> 32'(hi_len_ff) == ZPULSE_CYC)
    else $error("index pulse width wrong");
  a_fast_copy: assert property (!$past(rst) && !$past(rst, 2)
    |-> fast_pulse_is_onoff == ($past(fast_mode) == dofs_fast_onoff))
    else $error("mode flag does not follow");
  a_fast_bypass: assert property ((sel_fast == 6'h05 && !polarity[1]
    && fast_mode == dofs_fast_pulse)[*3] ##0 !$past(rst, 4)
    |-> fast_pulse_terminal == $past(st_fault, 2))
    else $error("fast terminal delayed in pulse mode");
endmodule
bind dofs_top dofs_top_props #(.MS_CYC(MS_CYC), .ZPULSE_CYC(ZPULSE_CYC)) u_props (
  .clock(clock), .rst(rst), .fast_mode(fast_mode), .sel_collector(sel_collector),
  .sel_fast(sel_fast), .sel_relay_a(sel_relay_a), .sel_relay_b(sel_relay_b),
  .polarity(polarity), .on_dly_collector(on_dly_collector),
  .off_dly_collector(off_dly_collector), .on_dly_relay_a(on_dly_relay_a),
  .off_dly_relay_a(off_dly_relay_a), .on_dly_relay_b(on_dly_relay_b),
  .off_dly_relay_b(off_dly_relay_b), .st_fault(st_fault),
  .card_collector_out_a(card_collector_out_a), .fast_pulse_terminal(fast_pulse_terminal),
  .fast_pulse_is_onoff(fast_pulse_is_onoff), .relay_out_a(relay_out_a),
  .relay_out_b(relay_out_b));
